//--- inc/elog_pkg.sv
// elog_pkg: shared constants and types of the event logger with overload guard
package elog_pkg;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned STAMP_RES_NS = 1_000_000;
	localparam int unsigned MS_CYCLES = STAMP_RES_NS / CLK_PERIOD_NS;
	localparam int unsigned OVL_WINDOW_S = 1;
	localparam int unsigned OVL_WINDOW_MS = OVL_WINDOW_S * 1000;
	localparam int unsigned OVL_THRESHOLD = 200;
	localparam int unsigned RELEASE_S = 5;
	localparam int unsigned RELEASE_MS = RELEASE_S * 1000;
	localparam int unsigned DIG_PERIOD_MS = 5;
	localparam int unsigned DIG_RATE_HZ = 1000 / DIG_PERIOD_MS;
	// ----------------------------------------
	// history and recorder sizes
	// ----------------------------------------
	localparam int unsigned HIST_DEPTH = 15_000;
	localparam int unsigned SAMPLE_SHIFT = 2;
	localparam logic [31:0] STORE_SPACE_BYTES = 32'h0400_0000;
	localparam logic [31:0] STORE_BYTES_RST = 32'h03d5_4b9c;
	localparam logic [31:0] REC_FN_RST = 32'h0000_0032;
	localparam logic [31:0] REC_AN_RST = 32'h0000_0009;
	localparam logic [31:0] REC_SPC_RST = 32'h0000_0040;
	localparam logic [31:0] REC_DIG_RST = 32'h0000_0002;
	localparam logic [31:0] MASK_RST = 32'hffff_ffff;
	// ----------------------------------------
	// entry layout: stamp in the upper word, code below
	// ----------------------------------------
	localparam int unsigned STAMP_W = 32;
	localparam int unsigned CODE_W = 16;
	localparam int unsigned CAP_FLAG_BIT = 15;
	localparam int unsigned FN_ID_W = 5;
	localparam int unsigned FN_CODE_W = 8;
	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_EV_MASK = 8'h08;
	localparam logic [7:0] REG_EV_COUNT = 8'h0c;
	localparam logic [7:0] REG_HIST_IDX = 8'h10;
	localparam logic [7:0] REG_HIST_STAMP = 8'h14;
	localparam logic [7:0] REG_HIST_CODE = 8'h18;
	localparam logic [7:0] REG_TIME_MS = 8'h1c;
	localparam logic [7:0] REG_REC_BYTES = 8'h20;
	localparam logic [7:0] REG_REC_FN = 8'h24;
	localparam logic [7:0] REG_REC_AN = 8'h28;
	localparam logic [7:0] REG_REC_SPC = 8'h2c;
	localparam logic [7:0] REG_REC_DIG = 8'h30;
	localparam logic [7:0] REG_REC_LEN = 8'h34;
	localparam int unsigned CTRL_FAULT_CLR = 0;
	localparam int unsigned CTRL_REC_LOAD = 1;
	localparam int unsigned ST_BLOCKED = 0;
	localparam int unsigned ST_FAULT = 1;
	localparam int unsigned ST_CALC_BUSY = 2;
	localparam int unsigned ST_FULL = 3;
	localparam int unsigned ST_LEN_VALID = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [0:0] {
		GUARD_OPEN = 1'h0,
		GUARD_BLOCKED = 1'h1
	} elog_guard_t;
	typedef enum logic [3:0] {
		CAP_TRIG_ON = 4'h0,
		CAP_TRIG_OFF = 4'h1,
		CAP_MEM_CLEARED = 4'h2,
		CAP_OLDEST_CLEARED = 4'h3,
		CAP_MEM_FULL_ON = 4'h4,
		CAP_MEM_FULL_OFF = 4'h5,
		CAP_REC_ON = 4'h6,
		CAP_REC_OFF = 4'h7,
		CAP_STORE_ON = 4'h8,
		CAP_STORE_OFF = 4'h9,
		CAP_NEWEST_CLEARED = 4'ha
	} elog_cap_kind_t;

	function automatic logic [31:0] elog_merge(input logic [31:0] old, input logic [31:0] dat,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
			begin
				res[i*8 +: 8] = dat[i*8 +: 8];
			end
		end
		return res;
	endfunction : elog_merge
endpackage : elog_pkg

//--- hw/elog_tick.sv
// elog_tick: divides a step input into one tick pulse every DIV steps
`timescale 1ns/1ps
`default_nettype none
module elog_tick import elog_pkg::*; #(
	parameter int unsigned DIV = 5
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// steps in, tick out
	input wire logic step,
	output logic tick
);
	localparam int unsigned CW = $clog2(DIV + 1);
	typedef struct packed {
		logic [CW-1:0] cnt;
		logic tick;
	} elog_tick_t;
	elog_tick_t s, next_s;

	always_comb
	begin
		next_s = s;
		next_s.tick = 1'b0;
		if (step)
		begin
			if (s.cnt == CW'(DIV - 1))
			begin
				next_s.cnt = '0;
				next_s.tick = 1'b1;
			end
			else
			begin
				next_s.cnt = s.cnt + CW'(1);
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			s <= '0;
		else
			s <= next_s;
	end

	assign tick = s.tick;
endmodule : elog_tick
`default_nettype wire

//--- hw/elog_div.sv
// elog_div: restoring divider, one quotient bit per clock
`timescale 1ns/1ps
`default_nettype none
module elog_div import elog_pkg::*; #(
	parameter int unsigned W = 32
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// operands
	input wire logic start,
	input wire logic [W-1:0] dividend,
	input wire logic [W-1:0] divisor,
	// result
	output logic busy,
	output logic done,
	output logic [W-1:0] quotient
);
	localparam int unsigned CW = $clog2(W + 1);
	typedef struct packed {
		logic busy;
		logic done;
		logic [CW-1:0] cnt;
		logic [W:0] rem;
		logic [W-1:0] quo;
		logic [W-1:0] dvs;
	} elog_div_t;
	elog_div_t s, next_s;
	logic [W:0] trial;

	always_comb
	begin
		next_s = s;
		next_s.done = 1'b0;
		trial = {s.rem[W-1:0], s.quo[W-1]};
		if (s.busy)
		begin
			// a zero divisor yields all ones
			if (trial >= {1'b0, s.dvs})
			begin
				next_s.rem = trial - {1'b0, s.dvs};
				next_s.quo = {s.quo[W-2:0], 1'b1};
			end
			else
			begin
				next_s.rem = trial;
				next_s.quo = {s.quo[W-2:0], 1'b0};
			end
			next_s.cnt = s.cnt - CW'(1);
			if (s.cnt == CW'(1))
			begin
				next_s.busy = 1'b0;
				next_s.done = 1'b1;
			end
		end
		else if (start)
		begin
			next_s.busy = 1'b1;
			next_s.cnt = CW'(W);
			next_s.rem = '0;
			next_s.quo = dividend;
			next_s.dvs = divisor;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			s <= '0;
		else
			s <= next_s;
	end

	assign busy = s.busy;
	assign done = s.done;
	assign quotient = s.quo;
endmodule : elog_div
`default_nettype wire

//--- hw/elog_top.sv
// elog_top: event history with time stamps, overload guard and recorder capacity calculator
// ----------------------------------------
// Summary of operation
// - every stored event carries a millisecond stamp
// - history holds at most fifteen thousand events
// - when full, oldest event makes room
// - function events stored only if mask allows
// - overload is over two hundred events per second
// - overload blocks logging and raises fault indication
// - release after five quiet seconds; fault then clears only by a control write
// - blocking never stalls event sources; function source stalls only while a capture event is valid
// - capture unit events bypass every mask
// - capture unit reports its eleven status changes
// - capture unit events are stamped too
// - sample reserve is storage bytes over four
// - each analog instant adds one stamp word
// - digital channels sampled every five milliseconds
// - recording length computed when settings load
// - storage space assumed sixty-four megabytes, unshared
// ----------------------------------------
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module elog_top import elog_pkg::*; #(
	parameter int unsigned DEPTH = HIST_DEPTH,
	parameter int unsigned MS_CYC = MS_CYCLES,
	parameter int unsigned WINDOW_MS = OVL_WINDOW_MS,
	parameter int unsigned REL_MS = RELEASE_MS
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// axi4-lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// function status-change events
	input wire logic fn_ev_valid,
	output logic fn_ev_ready,
	input wire logic [FN_ID_W-1:0] fn_ev_id,
	input wire logic [FN_CODE_W-1:0] fn_ev_code,
	// capture_event_group from the disturbance_capture_unit
	input wire logic cap_ev_valid,
	output logic cap_ev_ready,
	input wire elog_cap_kind_t cap_ev_kind,
	// status outputs
	output logic internal_fault_indication,
	output logic event_block,
	output logic dig_sample_tick,
	output logic [31:0] rec_len_s,
	output logic rec_len_valid
);
	localparam int unsigned IW = $clog2(DEPTH);
	localparam int unsigned NW = $clog2(DEPTH + 1);
	localparam int unsigned EW = STAMP_W + CODE_W;

	typedef struct packed {
		elog_guard_t guard;
		logic fault;
		logic [31:0] now_ms;
		logic [15:0] win_cnt;
		logic [15:0] quiet_ms;
		logic [IW-1:0] head;
		logic [IW-1:0] tail;
		logic [NW-1:0] count;
		logic [31:0] mask;
		logic [IW-1:0] hist_idx;
		logic [31:0] rec_bytes;
		logic [31:0] rec_fn;
		logic [31:0] rec_an;
		logic [31:0] rec_spc;
		logic [31:0] rec_dig;
		logic rec_start;
		logic [31:0] rec_len;
		logic len_valid;
		logic aw_hold;
		logic [7:0] aw_addr;
		logic w_hold;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} elog_state_t;
	elog_state_t s, next_s;

	logic [EW-1:0] hist [DEPTH];
	logic ms_tick, win_tick, div_busy, div_done;
	logic [31:0] div_q, reserve, denom;
	logic fn_hs, cap_hs, generated, trip, store, full;
	logic [CODE_W-1:0] code;
	logic [IW:0] phys_sum;
	logic [IW-1:0] phys;
	logic [31:0] rd_val;
	logic rd_ok, wr_ok, do_write;

	// ----------------------------------------
	// time base
	// ----------------------------------------
	elog_tick #(.DIV(MS_CYC)) u_ms (.clk(clk), .srst(srst), .step(1'b1), .tick(ms_tick));
	elog_tick #(.DIV(WINDOW_MS)) u_win (.clk(clk), .srst(srst), .step(ms_tick), .tick(win_tick));
	elog_tick #(.DIV(DIG_PERIOD_MS)) u_dig (.clk(clk), .srst(srst), .step(ms_tick), .tick(dig_sample_tick));

	// ----------------------------------------
	// recorder capacity
	// ----------------------------------------
	always_comb
	begin
		reserve = ((s.rec_bytes > STORE_SPACE_BYTES) ? STORE_SPACE_BYTES : s.rec_bytes) >> SAMPLE_SHIFT;
		denom = 32'(s.rec_fn * (s.rec_an + 32'h1) * s.rec_spc) + 32'(DIG_RATE_HZ * s.rec_dig);
	end

	elog_div #(.W(32)) u_div (
		.clk(clk),
		.srst(srst),
		.start(s.rec_start),
		.dividend(reserve),
		.divisor(denom),
		.busy(div_busy),
		.done(div_done),
		.quotient(div_q)
	);

	// ----------------------------------------
	// event intake
	// ----------------------------------------
	assign cap_ev_ready = 1'b1;
	assign fn_ev_ready = ~cap_ev_valid;
	always_comb
	begin
		cap_hs = cap_ev_valid;
		fn_hs = fn_ev_valid & fn_ev_ready;
		generated = cap_hs | (fn_hs & s.mask[fn_ev_id]);
		trip = generated & (s.win_cnt >= 16'(OVL_THRESHOLD));
		store = generated & (s.guard == GUARD_OPEN) & ~trip;
		full = (s.count == NW'(DEPTH));
		if (cap_hs)
			code = {1'b1, 11'h000, cap_ev_kind};
		else
			code = {1'b0, 2'h0, fn_ev_id, fn_ev_code};
	end

	always_ff @(posedge clk)
	begin
		if (store)
			hist[s.tail] <= {s.now_ms, code};
	end

	// ----------------------------------------
	// register read decode
	// ----------------------------------------
	always_comb
	begin
		phys_sum = {1'b0, s.head} + {1'b0, s.hist_idx};
		phys = (phys_sum >= (IW+1)'(DEPTH)) ? IW'(phys_sum - (IW+1)'(DEPTH)) : IW'(phys_sum);
		rd_ok = 1'b1;
		rd_val = '0;
		case (s_axi_araddr)
			REG_CTRL: rd_val = '0;
			REG_STATUS:
			begin
				rd_val[ST_BLOCKED] = (s.guard == GUARD_BLOCKED);
				rd_val[ST_FAULT] = s.fault;
				rd_val[ST_CALC_BUSY] = div_busy | s.rec_start;
				rd_val[ST_FULL] = full;
				rd_val[ST_LEN_VALID] = s.len_valid;
			end
			REG_EV_MASK: rd_val = s.mask;
			REG_EV_COUNT: rd_val = 32'(s.count);
			REG_HIST_IDX: rd_val = 32'(s.hist_idx);
			REG_HIST_STAMP: rd_val = hist[phys][EW-1:CODE_W];
			REG_HIST_CODE: rd_val = 32'(hist[phys][CODE_W-1:0]);
			REG_TIME_MS: rd_val = s.now_ms;
			REG_REC_BYTES: rd_val = s.rec_bytes;
			REG_REC_FN: rd_val = s.rec_fn;
			REG_REC_AN: rd_val = s.rec_an;
			REG_REC_SPC: rd_val = s.rec_spc;
			REG_REC_DIG: rd_val = s.rec_dig;
			REG_REC_LEN: rd_val = s.rec_len;
			default: rd_ok = 1'b0;
		endcase
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		next_s = s;
		next_s.rec_start = 1'b0;
		do_write = s.aw_hold & s.w_hold & ~s.bvalid;
		wr_ok = 1'b0;
		// time stamp counter
		if (ms_tick)
			next_s.now_ms = s.now_ms + 32'h1;
		// events per window, restarted by the window tick
		if (win_tick)
			next_s.win_cnt = generated ? 16'h1 : 16'h0;
		else if (generated && s.win_cnt != 16'hffff)
			next_s.win_cnt = s.win_cnt + 16'h1;
		// overload guard
		case (s.guard)
			GUARD_OPEN:
			begin
				if (trip)
				begin
					next_s.guard = GUARD_BLOCKED;
					next_s.quiet_ms = '0;
				end
			end
			GUARD_BLOCKED:
			begin
				if (trip)
					next_s.quiet_ms = '0;
				else if (ms_tick)
				begin
					if (s.quiet_ms == 16'(REL_MS - 1))
						next_s.guard = GUARD_OPEN;
					else
						next_s.quiet_ms = s.quiet_ms + 16'h1;
				end
			end
			default: next_s.guard = GUARD_OPEN;
		endcase
		// history pointers
		if (store)
		begin
			next_s.tail = (s.tail == IW'(DEPTH - 1)) ? '0 : s.tail + IW'(1);
			if (full)
				next_s.head = (s.head == IW'(DEPTH - 1)) ? '0 : s.head + IW'(1);
			else
				next_s.count = s.count + NW'(1);
		end
		// write channel
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_s.aw_hold = 1'b1;
			next_s.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_s.w_hold = 1'b1;
			next_s.w_data = s_axi_wdata;
			next_s.w_strb = s_axi_wstrb;
		end
		if (do_write)
		begin
			wr_ok = 1'b1;
			case (s.aw_addr)
				REG_CTRL:
				begin
					if (s.w_strb[0] && s.w_data[CTRL_REC_LOAD])
					begin
						next_s.rec_start = 1'b1;
						next_s.len_valid = 1'b0;
					end
				end
				REG_EV_MASK: next_s.mask = elog_merge(s.mask, s.w_data, s.w_strb);
				REG_HIST_IDX: next_s.hist_idx = IW'(elog_merge(32'(s.hist_idx), s.w_data, s.w_strb));
				REG_REC_BYTES: next_s.rec_bytes = elog_merge(s.rec_bytes, s.w_data, s.w_strb);
				REG_REC_FN: next_s.rec_fn = elog_merge(s.rec_fn, s.w_data, s.w_strb);
				REG_REC_AN: next_s.rec_an = elog_merge(s.rec_an, s.w_data, s.w_strb);
				REG_REC_SPC: next_s.rec_spc = elog_merge(s.rec_spc, s.w_data, s.w_strb);
				REG_REC_DIG: next_s.rec_dig = elog_merge(s.rec_dig, s.w_data, s.w_strb);
				REG_STATUS, REG_EV_COUNT, REG_HIST_STAMP, REG_HIST_CODE, REG_TIME_MS, REG_REC_LEN: wr_ok = 1'b1;
				default: wr_ok = 1'b0;
			endcase
			next_s.aw_hold = 1'b0;
			next_s.w_hold = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s.bvalid && s_axi_bready)
			next_s.bvalid = 1'b0;
		// fault indication: a new trip wins over a clear
		if (do_write && s.aw_addr == REG_CTRL && s.w_strb[0] && s.w_data[CTRL_FAULT_CLR]
			&& s.guard == GUARD_OPEN)
			next_s.fault = 1'b0;
		if (trip)
			next_s.fault = 1'b1;
		// recorder length display
		if (div_done)
		begin
			next_s.rec_len = div_q;
			next_s.len_valid = 1'b1;
		end
		// read channel
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_s.rvalid = 1'b1;
			next_s.rdata = rd_val;
			next_s.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s.rvalid && s_axi_rready)
			next_s.rvalid = 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			s <= '0;
			s.guard <= GUARD_OPEN;
			s.mask <= MASK_RST;
			s.rec_bytes <= STORE_BYTES_RST;
			s.rec_fn <= REC_FN_RST;
			s.rec_an <= REC_AN_RST;
			s.rec_spc <= REC_SPC_RST;
			s.rec_dig <= REC_DIG_RST;
		end
		else
			s <= next_s;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign s_axi_awready = ~s.aw_hold & ~s.bvalid;
	assign s_axi_wready = ~s.w_hold & ~s.bvalid;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = ~s.rvalid;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign internal_fault_indication = s.fault;
	assign event_block = (s.guard == GUARD_BLOCKED);
	assign rec_len_s = s.rec_len;
	assign rec_len_valid = s.len_valid;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	stamp_step_a: assert property (ms_tick |=> s.now_ms == $past(s.now_ms) + 32'h1) else $error("stamp stuck");
	hist_bound_a: assert property (s.count <= NW'(DEPTH)) else $error("history over depth");
	drop_oldest_a: assert property (store && full |=> full && s.head != $past(s.head)) else $error("no drop");
	mask_gate_a: assert property (store && !cap_ev_valid |-> s.mask[fn_ev_id]) else $error("masked event stored");
	trip_block_a: assert property (trip |=> event_block && s.fault) else $error("overload not blocked");
	block_drop_a: assert property (event_block |-> !store) else $error("event stored while blocked");
	release_time_a: assert property ($fell(event_block) |-> s.quiet_ms == 16'(REL_MS - 1)) else $error("early release");
	fault_hold_a: assert property (event_block && s.fault |=> s.fault) else $error("fault cleared while blocked");
	src_ready_a: assert property (!cap_ev_valid |-> fn_ev_ready) else $error("function source stalled");
	cap_bypass_a: assert property (cap_ev_valid && !event_block && !trip |-> store) else $error("capture lost");
	calc_show_a: assert property (div_done |=> s.len_valid && s.rec_len == $past(div_q)) else $error("no length");

	trip_seen_c: cover property (trip ##1 event_block);
	release_seen_c: cover property (event_block ##1 !event_block);
	wrap_store_c: cover property (store && full);
	calc_done_c: cover property (s.rec_start ##[1:40] div_done);
endmodule : elog_top
`default_nettype wire

//--- testbench/elog_top_tb.sv
// elog_top_tb: self-checking bench of the event logger with overload guard
`timescale 1ns/1ps
`default_nettype none
module elog_top_tb import elog_pkg::*; ;
	localparam int unsigned MSC = 10;
	localparam int unsigned WIN = 40;
	localparam int unsigned REL = 5;
	localparam int unsigned DEP = 8;
	logic clk, srst;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata, rec_len_s;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic fn_ev_valid, fn_ev_ready, cap_ev_valid, cap_ev_ready;
	logic [4:0] fn_ev_id;
	logic [7:0] fn_ev_code;
	elog_cap_kind_t cap_ev_kind;
	logic internal_fault_indication, event_block, dig_sample_tick, rec_len_valid;
	int fails = 0;
	int num_checks = 0;
	int cyc = 0;
	integer seed = 26514;

	elog_top #(.DEPTH(DEP), .MS_CYC(MSC), .WINDOW_MS(WIN), .REL_MS(REL)) dut_u (.clk(clk), .srst(srst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .fn_ev_valid(fn_ev_valid),
		.fn_ev_ready(fn_ev_ready), .fn_ev_id(fn_ev_id), .fn_ev_code(fn_ev_code), .cap_ev_valid(cap_ev_valid),
		.cap_ev_ready(cap_ev_ready), .cap_ev_kind(cap_ev_kind), .internal_fault_indication(internal_fault_indication),
		.event_block(event_block), .dig_sample_tick(dig_sample_tick), .rec_len_s(rec_len_s),
		.rec_len_valid(rec_len_valid));

	always #5 clk = ~clk;

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			fails++;
			tally_and_finish();
		end
	end

	// ----------------------------------------
	// compare, expectations and bus tasks
	// ----------------------------------------
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	function automatic logic [31:0] exp_len(input logic [31:0] b, f, a, s, d);
		logic [31:0] den;
		den = f * (a + 32'h1) * s + 32'hc8 * d;
		if (b > STORE_SPACE_BYTES)
			b = STORE_SPACE_BYTES;
		return (den == 32'h0) ? 32'hffff_ffff : (b >> 2) / den;
	endfunction : exp_len

	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw, ad, wd, tb;
		ad = 1'b0;
		wd = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(ad && wd))
		begin
			@(negedge clk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			@(posedge clk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
			ad = ad | ta;
			wd = wd | tw;
		end
		s_axi_bready <= 1'b1;
		do
		begin
			@(negedge clk);
			tb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clk);
		end
		while (!tb);
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic t;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do
		begin
			@(negedge clk);
			t = s_axi_arready;
			@(posedge clk);
		end
		while (!t);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do
		begin
			@(negedge clk);
			t = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clk);
		end
		while (!t);
		s_axi_rready <= 1'b0;
	endtask : rd

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
	endtask : wreg

	task automatic chk_rd(input string n, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		check(n, d, e);
	endtask : chk_rd

	task automatic set_rec(input logic [31:0] b, f, a, s, d);
		int n;
		wreg(REG_REC_BYTES, b);
		wreg(REG_REC_FN, f);
		wreg(REG_REC_AN, a);
		wreg(REG_REC_SPC, s);
		wreg(REG_REC_DIG, d);
		wreg(REG_CTRL, 32'h2);
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (rec_len_valid !== 1'b1 && n < 100);
		check("length valid", {31'h0, rec_len_valid}, 32'h1);
		check("length", rec_len_s, exp_len(b, f, a, s, d));
		@(posedge clk);
		chk_rd("length reg", REG_REC_LEN, exp_len(b, f, a, s, d));
	endtask : set_rec

	task automatic fn_ev(input logic [4:0] id, input logic [7:0] code);
		fn_ev_id <= id;
		fn_ev_code <= code;
		fn_ev_valid <= 1'b1;
		@(posedge clk);
		fn_ev_valid <= 1'b0;
		@(posedge clk);
	endtask : fn_ev

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		logic [31:0] d, t0, old;
		logic blk;
		logic [1:0] r;
		int n;
		clk = 1'b0;
		srst = 1'b1;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, fn_ev_valid, fn_ev_id, fn_ev_code, cap_ev_valid} = '0;
		s_axi_wstrb = 4'hf;
		cap_ev_kind = CAP_TRIG_ON;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		chk_rd("mask reset", REG_EV_MASK, MASK_RST);
		chk_rd("count reset", REG_EV_COUNT, 32'h0);
		rd(8'h3c, d, r);
		check("unmapped resp", {30'h0, r}, {30'h0, RESP_SLVERR});
		wr(8'h3c, 32'h0, r);
		check("unmapped wr resp", {30'h0, r}, {30'h0, RESP_SLVERR});
		set_rec(STORE_BYTES_RST, REC_FN_RST, REC_AN_RST, REC_SPC_RST, REC_DIG_RST);
		check("default length", rec_len_s, 32'h0000_01f0);
		wr(REG_REC_LEN, 32'h0, r);
		check("read-only resp", {30'h0, r}, {30'h0, RESP_OKAY});
		chk_rd("length read-only", REG_REC_LEN, 32'h0000_01f0);
		set_rec(32'h0010_0000, 32'h0, 32'h3, 32'h40, 32'h0);
		repeat (4) set_rec($random(seed), 32'h10 + ($random(seed) & 32'h2f), $random(seed) & 32'hf,
			32'h8 + ($random(seed) & 32'hf7), $random(seed) & 32'hf);
		// masked functions dropped, capture events still stored
		wreg(REG_EV_MASK, 32'h0);
		fn_ev($random(seed), $random(seed));
		chk_rd("masked count", REG_EV_COUNT, 32'h0);
		for (int k = 0; k < 11; k++)
		begin
			cap_ev_kind <= elog_cap_kind_t'(k[3:0]);
			cap_ev_valid <= 1'b1;
			@(posedge clk);
			cap_ev_valid <= 1'b0;
			@(posedge clk);
		end
		chk_rd("full count", REG_EV_COUNT, DEP);
		chk_rd("full status", REG_STATUS, 32'h18);
		for (int i = 0; i < DEP; i++)
		begin
			wreg(REG_HIST_IDX, i);
			chk_rd("capture code", REG_HIST_CODE, 32'h8000 + i + 3);
		end
		wreg(REG_EV_MASK, 32'hffff_ffff);
		rd(REG_TIME_MS, t0, r);
		fn_ev(5'h05, 8'h5a);
		chk_rd("function code", REG_HIST_CODE, 32'h0000_055a);
		rd(REG_HIST_STAMP, d, r);
		check("stamp age", {31'h0, (d - t0) <= 32'h1}, 32'h1);
		// digital sample period
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (dig_sample_tick !== 1'b1 && n < 200);
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (dig_sample_tick !== 1'b1 && n < 200);
		check("tick period", n, 5 * MSC);
		@(posedge clk);
		// overload: a quiet window first so the count starts at zero, then stream until the guard trips
		repeat (WIN * MSC) @(posedge clk);
		n = 0;
		fn_ev_valid <= 1'b1;
		do
		begin
			fn_ev_id <= $random(seed);
			fn_ev_code <= $random(seed);
			@(negedge clk);
			n++;
			blk = event_block;
			@(posedge clk);
		end
		while (blk !== 1'b1 && n < 1000);
		fn_ev_valid <= 1'b0;
		@(posedge clk);
		check("events to trip", {31'h0, n > 200}, 32'h1);
		check("fault raised", {31'h0, internal_fault_indication}, 32'h1);
		check("ready while blocked", {31'h0, fn_ev_ready}, 32'h1);
		check("capture ready", {31'h0, cap_ev_ready}, 32'h1);
		chk_rd("blocked status", REG_STATUS, 32'h1b);
		rd(REG_HIST_CODE, old, r);
		fn_ev(5'h01, 8'hc3);
		chk_rd("blocked drop", REG_HIST_CODE, old);
		wreg(REG_CTRL, 32'h1);
		check("clear while blocked", {31'h0, internal_fault_indication}, 32'h1);
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (event_block !== 1'b0 && n < 300);
		check("released", {31'h0, event_block}, 32'h0);
		check("fault held", {31'h0, internal_fault_indication}, 32'h1);
		@(posedge clk);
		wreg(REG_CTRL, 32'h1);
		check("fault cleared", {31'h0, internal_fault_indication}, 32'h0);
		// let a window pass so the next event does not trip again
		repeat (WIN * MSC) @(posedge clk);
		fn_ev(5'h02, 8'h77);
		chk_rd("logging resumed", REG_HIST_CODE, 32'h0000_0277);
		tally_and_finish();
	end
endmodule : elog_top_tb
`default_nettype wire
